// ---- cpu_bus_model.sv ----
// cpu_bus_model: AXI4-Lite master that stands in for the core on the timer bus
// assumes one clock; registers hold one byte in bits 7:0 of an aligned word
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // cycles of delay before taking a response
  int slow = 0;
  // byte strobes for the next write
  logic [3:0] strb = 4'hF;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    repeat (slow) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid || !bready);
    resp = bresp;
    bready <= 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] resp);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    repeat (slow) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid || !rready);
    d = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask : read_reg
endmodule : cpu_bus_model

// ---- programmable_timer_irq.sv ----
// programmable_timer_irq: 16-bit free running timer with capture, compare, overflow
// assumes SYS_CLK at 20 MHz, CAPTURE_IN asynchronous, AXI4-Lite master on the bus
//
// Functional notes
// - three flags in status bits seven to five
// - all flags share one interrupt request
// - request needs flag and matching enable
// - reset clears all three interrupt enables
// - request reaches core only when mask clear
// - flag clear: status access, then data access
// - timer keeps running during core wait state
// - fixed divide-by-four prescaler before counter
// - each function is high/low byte pair
// - high byte access suspends until low access
// - eleven consecutive byte registers decoded
// - reset touches only counter, control and core
// - capture edge sets flag at next flag-set state
// - compare evaluated only in compare state
// - compare flag set at following flag-set state
// - wrap to zero sets overflow at flag-set
// - overflow cleared by status then count low read
// - counter resets to FFFC, read-only
// - match sets flag and drives output level
// - selected edge latches counter plus one into capture
// - count high read buffers low byte
`timescale 1ns/1ps
module programmable_timer_irq (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CAPTURE_IN,
  output logic COMPARE_OUT,
  output logic TIMER_IRQ,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef enum logic [1:0] {ST_ZERO, ST_COMPARE, ST_TWO, ST_FLAG_SET} tstate_e;
  tstate_e tstate;
  logic [15:0] count;
  logic [15:0] capture;
  logic [15:0] compare;
  logic [7:0] timer_control;
  logic capture_flag, compare_flag, overflow_flag;
  logic [1:0] core;
  logic [7:0] low_buf;
  logic cap_hold, cmp_hold, cap_hold_cnt;
  logic arm_cap, arm_cmp, arm_ovf;
  logic cap_pend, cmp_pend, ovf_pend;
  logic sync1, sync2, sync3;
  logic [31:0] aw_addr, ar_addr;
  logic aw_have, w_have;
  logic [7:0] w_byte;
  logic w_en;
  logic wr_go, rd_go;
  logic [7:0] wr_idx, rd_idx;
  logic edge_seen;
  logic [7:0] next_rdata;
  logic rd_ok, wr_ok;

  // four timer states, counter steps at the flag-set state
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tstate <= ST_ZERO;
    end else begin
      case (tstate)
        ST_ZERO: tstate <= ST_COMPARE;
        ST_COMPARE: tstate <= ST_TWO;
        ST_TWO: tstate <= ST_FLAG_SET;
        default: tstate <= ST_ZERO;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= timer_pkg::COUNT_RESET;
    end else if (tstate == ST_FLAG_SET) begin
      count <= count + 16'h0001;
    end
  end

  // capture input synchroniser and edge detect
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= CAPTURE_IN;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign edge_seen = timer_control[timer_pkg::BIT_EDGE] ? (sync2 && !sync3) : (!sync2 && sync3);

  // bus handshake: write address and data taken in either order
  assign wr_go = aw_have && w_have && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_idx = aw_addr[9:2];
  assign rd_idx = S_AXI_ARADDR[9:2];
  assign wr_ok = (aw_addr[31:10] == 22'h000000) && (wr_idx >= timer_pkg::IDX_CONTROL)
    && (wr_idx <= timer_pkg::IDX_CORE);
  assign rd_ok = (S_AXI_ARADDR[31:10] == 22'h000000) && (rd_idx >= timer_pkg::IDX_CONTROL)
    && (rd_idx <= timer_pkg::IDX_CORE);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h00000000;
      w_byte <= 8'h00;
      w_en <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= timer_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_have && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_have && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have <= 1'b1;
        w_byte <= S_AXI_WDATA[7:0];
        w_en <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_idx == timer_pkg::IDX_CONTROL) begin
      next_rdata = timer_control;
    end else if (rd_idx == timer_pkg::IDX_STATUS) begin
      next_rdata = {capture_flag, compare_flag, overflow_flag, 5'h00};
    end else if (rd_idx == timer_pkg::IDX_CAP_HI) begin
      next_rdata = capture[15:8];
    end else if (rd_idx == timer_pkg::IDX_CAP_LO) begin
      next_rdata = capture[7:0];
    end else if (rd_idx == timer_pkg::IDX_CMP_HI) begin
      next_rdata = compare[15:8];
    end else if (rd_idx == timer_pkg::IDX_CMP_LO) begin
      next_rdata = compare[7:0];
    end else if (rd_idx == timer_pkg::IDX_CNT_HI || rd_idx == timer_pkg::IDX_ALT_HI) begin
      next_rdata = count[15:8];
    end else if (rd_idx == timer_pkg::IDX_CNT_LO || rd_idx == timer_pkg::IDX_ALT_LO) begin
      next_rdata = cap_hold_cnt ? low_buf : count[7:0];
    end else if (rd_idx == timer_pkg::IDX_CORE) begin
      next_rdata = {6'h00, core};
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= timer_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_ok ? {24'h000000, next_rdata} : 32'h00000000;
        S_AXI_RRESP <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // counter read buffer: first high read freezes the low byte
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cap_hold_cnt <= 1'b0;
      low_buf <= 8'h00;
    end else if (rd_go && rd_ok) begin
      if ((rd_idx == timer_pkg::IDX_CNT_HI || rd_idx == timer_pkg::IDX_ALT_HI)
          && !cap_hold_cnt) begin
        cap_hold_cnt <= 1'b1;
        low_buf <= count[7:0];
      end else if (rd_idx == timer_pkg::IDX_CNT_LO || rd_idx == timer_pkg::IDX_ALT_LO) begin
        cap_hold_cnt <= 1'b0;
      end
    end
  end

  // control and core registers; only control, core and counter reset
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_control <= timer_pkg::CONTROL_RESET;
      core <= timer_pkg::CORE_RESET;
    end else if (wr_go && wr_ok && w_en) begin
      if (wr_idx == timer_pkg::IDX_CONTROL) begin
        timer_control <= w_byte;
      end else if (wr_idx == timer_pkg::IDX_CORE) begin
        core <= w_byte[1:0];
      end
    end
  end

  // compare register, suspended between high and low writes
  always_ff @(posedge SYS_CLK) begin
    if (wr_go && wr_ok && w_en && wr_idx == timer_pkg::IDX_CMP_HI) begin
      compare[15:8] <= w_byte;
    end
    if (wr_go && wr_ok && w_en && wr_idx == timer_pkg::IDX_CMP_LO) begin
      compare[7:0] <= w_byte;
    end
  end
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_hold <= 1'b0;
      cap_hold <= 1'b0;
    end else begin
      if (wr_go && wr_ok && w_en && wr_idx == timer_pkg::IDX_CMP_HI) begin
        cmp_hold <= 1'b1;
      end else if (wr_go && wr_ok && w_en && wr_idx == timer_pkg::IDX_CMP_LO) begin
        cmp_hold <= 1'b0;
      end
      if (rd_go && rd_ok && rd_idx == timer_pkg::IDX_CAP_HI) begin
        cap_hold <= 1'b1;
      end else if (rd_go && rd_ok && rd_idx == timer_pkg::IDX_CAP_LO) begin
        cap_hold <= 1'b0;
      end
    end
  end

  // capture latch: counter plus one, not touched by reset
  always_ff @(posedge SYS_CLK) begin
    if (edge_seen && !cap_hold) begin
      capture <= count + 16'h0001;
    end
  end

  // pending events wait for the flag-set state
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cap_pend <= 1'b0;
      cmp_pend <= 1'b0;
      ovf_pend <= 1'b0;
      COMPARE_OUT <= 1'b0;
    end else begin
      if (edge_seen && !cap_hold) begin
        cap_pend <= 1'b1;
      end else if (tstate == ST_FLAG_SET) begin
        cap_pend <= 1'b0;
      end
      if (tstate == ST_COMPARE && !cmp_hold && compare == count) begin
        cmp_pend <= 1'b1;
        COMPARE_OUT <= timer_control[timer_pkg::BIT_LEVEL];
      end else if (tstate == ST_FLAG_SET) begin
        cmp_pend <= 1'b0;
      end
      ovf_pend <= (tstate == ST_TWO) && (count == 16'hFFFF);
    end
  end

  // flags: set wins over clear; arm by status read while set
  logic rd_status, acc_cap, acc_cmp, rd_cnt_lo;
  assign rd_status = rd_go && rd_ok && rd_idx == timer_pkg::IDX_STATUS;
  assign acc_cap = rd_go && rd_ok && rd_idx == timer_pkg::IDX_CAP_LO;
  assign acc_cmp = wr_go && wr_ok && w_en && wr_idx == timer_pkg::IDX_CMP_LO;
  assign rd_cnt_lo = rd_go && rd_ok
    && (rd_idx == timer_pkg::IDX_CNT_LO || rd_idx == timer_pkg::IDX_ALT_LO);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_cap <= 1'b0;
      arm_cmp <= 1'b0;
      arm_ovf <= 1'b0;
    end else begin
      if (rd_status) begin
        arm_cap <= capture_flag;
        arm_cmp <= compare_flag;
        arm_ovf <= overflow_flag;
      end else begin
        if (acc_cap) arm_cap <= 1'b0;
        if (acc_cmp) arm_cmp <= 1'b0;
        if (rd_cnt_lo) arm_ovf <= 1'b0;
      end
    end
  end

  // flags hold their value across reset
  always_ff @(posedge SYS_CLK) begin
    if (tstate == ST_FLAG_SET && cap_pend) begin
      capture_flag <= 1'b1;
    end else if (arm_cap && acc_cap) begin
      capture_flag <= 1'b0;
    end
    if (tstate == ST_FLAG_SET && cmp_pend) begin
      compare_flag <= 1'b1;
    end else if (arm_cmp && acc_cmp) begin
      compare_flag <= 1'b0;
    end
    if (tstate == ST_FLAG_SET && ovf_pend) begin
      overflow_flag <= 1'b1;
    end else if (arm_ovf && rd_cnt_lo) begin
      overflow_flag <= 1'b0;
    end
  end

  // shared request, gated by enables and core mask
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= !core[timer_pkg::BIT_MASK] && (
        (capture_flag && timer_control[timer_pkg::BIT_CAPTURE]) ||
        (compare_flag && timer_control[timer_pkg::BIT_COMPARE]) ||
        (overflow_flag && timer_control[timer_pkg::BIT_OVERFLOW]));
    end
  end

  count_step_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tstate == ST_FLAG_SET |=> count == $past(count) + 16'h0001)
    else $error("counter did not step");
  count_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tstate != ST_FLAG_SET |=> $stable(count))
    else $error("counter moved outside step");
  irq_gate_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    TIMER_IRQ |-> $past(timer_control[7:5] & {capture_flag, compare_flag, overflow_flag}) != 3'h0)
    else $error("request without enabled flag");
  irq_mask_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    TIMER_IRQ |-> !$past(core[timer_pkg::BIT_MASK]))
    else $error("request while masked");
  ovf_set_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tstate == ST_TWO && count == 16'hFFFF |=> ##1 overflow_flag)
    else $error("overflow flag not set");
  flag_state_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(compare_flag) |-> $past(tstate) == ST_FLAG_SET)
    else $error("compare flag set outside flag state");
  cap_state_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(capture_flag) |-> $past(tstate) == ST_FLAG_SET)
    else $error("capture flag set outside flag state");
  ovf_clear_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $fell(overflow_flag) |-> $past(rd_cnt_lo) && $past(arm_ovf))
    else $error("overflow cleared without sequence");
endmodule : programmable_timer_irq

// ---- programmable_timer_irq_tb_top.sv ----
// programmable_timer_irq_tb_top: register-level tests of the timer through the bus model
// assumes the timer package and a 20 MHz clock; capture input driven directly
`timescale 1ns/1ps
module programmable_timer_irq_tb_top;
  logic clk, arst_n, capture_in, compare_out, timer_irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t1, t2;
  logic [7:0] v, h, l, a, b;
  logic [15:0] c0, c1, tgt;
  programmable_timer_irq i_dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .CAPTURE_IN(capture_in), .COMPARE_OUT(compare_out),
    .TIMER_IRQ(timer_irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  cpu_bus_model i_cpu (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic [1:0] rr;
    i_cpu.read_reg(idx, d, rr);
    chk("read response", {14'h0, timer_pkg::RESP_OKAY}, {14'h0, rr});
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] rr;
    i_cpu.write_reg(idx, d, rr);
    chk("write response", {14'h0, timer_pkg::RESP_OKAY}, {14'h0, rr});
  endtask : wr
  // high byte first so the low byte comes from the buffer
  task automatic rd_count(output logic [15:0] c);
    rd(timer_pkg::IDX_CNT_HI, c[15:8]);
    rd(timer_pkg::IDX_CNT_LO, c[7:0]);
  endtask : rd_count
  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    capture_in = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(timer_pkg::IDX_CONTROL, v);
    chk("interrupt enables", 16'h0, {13'h0, v[7:5]});
    for (int i = 0; i < 2; i++) begin
      i_cpu.read_reg((i == 0) ? 8'h11 : 8'h1D, v, r);
      chk("unmapped response", {14'h0, timer_pkg::RESP_SLVERR}, {14'h0, r});
      chk("unmapped data", 16'h0, {8'h0, v});
    end
    i_cpu.write_reg(8'h11, 8'h55, r);
    chk("unmapped write", {14'h0, timer_pkg::RESP_SLVERR}, {14'h0, r});
    // counter starts near the top, so it has wrapped by now
    repeat (20) @(posedge clk);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("overflow flag", 1'b1, v[timer_pkg::BIT_OVERFLOW]);
    chk_bit("irq disabled", 1'b0, timer_irq);
    wr(timer_pkg::IDX_CONTROL, 8'h20);
    repeat (3) @(posedge clk);
    chk_bit("irq masked", 1'b0, timer_irq);
    wr(timer_pkg::IDX_CORE, 8'h00);
    repeat (3) @(posedge clk);
    chk_bit("overflow irq", 1'b1, timer_irq);
    i_cpu.slow = 3;
    wr(timer_pkg::IDX_CORE, 8'h01);
    rd(timer_pkg::IDX_STATUS, v);
    rd(timer_pkg::IDX_CNT_LO, v);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("overflow cleared", 1'b0, v[timer_pkg::BIT_OVERFLOW]);
    i_cpu.slow = 0;
    wr(timer_pkg::IDX_CORE, 8'h00);
    wr(timer_pkg::IDX_CONTROL, 8'h41);
    rd_count(c0);
    tgt = c0 + 16'h0030;
    wr(timer_pkg::IDX_CMP_HI, tgt[15:8]);
    wr(timer_pkg::IDX_CMP_LO, tgt[7:0]);
    repeat (300) @(posedge clk);
    chk_bit("compare level out", 1'b1, compare_out);
    chk_bit("compare irq", 1'b1, timer_irq);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("compare flag", 1'b1, v[timer_pkg::BIT_COMPARE]);
    rd_count(c0);
    tgt = c0 + 16'h0030;
    wr(timer_pkg::IDX_CMP_HI, tgt[15:8]);
    wr(timer_pkg::IDX_CMP_LO, tgt[7:0]);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("compare flag cleared", 1'b0, v[timer_pkg::BIT_COMPARE]);
    // high byte alone holds the compare off past the target
    wr(timer_pkg::IDX_CMP_HI, tgt[15:8]);
    repeat (300) @(posedge clk);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("compare suspended", 1'b0, v[timer_pkg::BIT_COMPARE]);
    wr(timer_pkg::IDX_CONTROL, 8'h82);
    rd_count(c0);
    capture_in <= 1'b1;
    repeat (12) @(posedge clk);
    rd_count(c1);
    chk_bit("capture irq", 1'b1, timer_irq);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("capture flag", 1'b1, v[timer_pkg::BIT_CAPTURE]);
    rd(timer_pkg::IDX_CAP_HI, h);
    rd(timer_pkg::IDX_CAP_LO, l);
    chk_bit("capture value", 1'b1, {h, l} >= c0 && {h, l} <= c1);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("capture cleared", 1'b0, v[timer_pkg::BIT_CAPTURE]);
    capture_in <= 1'b0;
    repeat (12) @(posedge clk);
    rd(timer_pkg::IDX_STATUS, v);
    chk_bit("falling edge ignored", 1'b0, v[timer_pkg::BIT_CAPTURE]);
    rd(timer_pkg::IDX_CNT_HI, h);
    repeat (40) @(posedge clk);
    rd(timer_pkg::IDX_CNT_LO, l);
    rd(timer_pkg::IDX_ALT_LO, a);
    chk_bit("low byte buffered", 1'b1, 8'(a - l) >= 8'd10);
    wr(timer_pkg::IDX_CORE, 8'h02);
    rd(timer_pkg::IDX_ALT_LO, a);
    t1 = cyc;
    repeat (200) @(posedge clk);
    rd(timer_pkg::IDX_ALT_LO, b);
    t2 = cyc;
    chk_bit("count rate", 1'b1, (4 * int'(8'(b - a)) - (t2 - t1)) inside {[-3:3]});
    // mid-run reset: only counter, control and core change
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(timer_pkg::IDX_CONTROL, v);
    chk("control after reset", 16'h0, {8'h0, v});
    rd_count(c0);
    chk_bit("counter after reset", 1'b1, c0 >= timer_pkg::COUNT_RESET);
    rd(timer_pkg::IDX_CMP_HI, h);
    rd(timer_pkg::IDX_CMP_LO, l);
    chk("compare kept", tgt, {h, l});
    // a write with no strobe on the low byte leaves the register alone
    i_cpu.strb = 4'h0;
    wr(timer_pkg::IDX_CONTROL, 8'hE0);
    i_cpu.strb = 4'hF;
    rd(timer_pkg::IDX_CONTROL, v);
    chk("strobe-less write", 16'h0, {8'h0, v});
    give_verdict();
  end
endmodule : programmable_timer_irq_tb_top

// ---- timer_pkg.sv ----
// timer_pkg: register offsets, field positions, reset values and counts for the timer
// assumes a 32-bit AXI4-Lite slave, byte registers in the low bits of each word
package timer_pkg;
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_STATUS = 8'h13;
  localparam logic [7:0] IDX_CAP_HI = 8'h14;
  localparam logic [7:0] IDX_CAP_LO = 8'h15;
  localparam logic [7:0] IDX_CMP_HI = 8'h16;
  localparam logic [7:0] IDX_CMP_LO = 8'h17;
  localparam logic [7:0] IDX_CNT_HI = 8'h18;
  localparam logic [7:0] IDX_CNT_LO = 8'h19;
  localparam logic [7:0] IDX_ALT_HI = 8'h1A;
  localparam logic [7:0] IDX_ALT_LO = 8'h1B;
  localparam logic [7:0] IDX_CORE = 8'h1C;
  // field positions shared by status flags and control enables, then control edge and level bits
  localparam int BIT_CAPTURE = 7;
  localparam int BIT_COMPARE = 6;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_EDGE = 1;
  localparam int BIT_LEVEL = 0;
  // core register: bit 0 mask, bit 1 wait
  localparam int BIT_MASK = 0;
  localparam int BIT_WAIT = 1;
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] CORE_RESET = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESCALE = 4;
endpackage : timer_pkg
